/* File: logic/cism_pkg.sv */
// Package: constants and types of the compact stack and memory executer
package cism_pkg;
  // Register byte offsets
  localparam logic [7:0]  ADDR_INSTR  = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_PC     = 8'h08;
  localparam logic [7:0]  ADDR_SP     = 8'h0c;
  localparam logic [7:0]  ADDR_LR     = 8'h10;
  localparam logic [7:0]  ADDR_FLAGS  = 8'h14;
  localparam logic [7:0]  ADDR_GPR    = 8'h20;
  // Opcode fields
  localparam logic [3:0]  OP_SPREL    = 4'h9;
  localparam logic [3:0]  OP_ADR      = 4'ha;
  localparam logic [7:0]  OP_ADJ      = 8'hb0;
  localparam logic [3:0]  OP_STACK    = 4'hb;
  localparam logic [1:0]  STACK_SUB   = 2'h2;
  localparam logic [3:0]  OP_MULTI    = 4'hc;
  // Arithmetic constants
  localparam logic [31:0] PC_AHEAD    = 32'h0000_0004;
  localparam logic [31:0] PC_BIT1     = 32'h0000_0002;
  localparam logic [31:0] PC_BIT0     = 32'h0000_0001;
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
  localparam logic [31:0] INSN_STEP   = 32'h0000_0002;
  // Internal cycles after the last load
  localparam logic [1:0]  LOAD_TAIL   = 2'h1;
  localparam logic [1:0]  PCLOAD_TAIL = 2'h3;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_MEM, S_TAIL} cism_state_type;
  typedef enum logic [2:0] {K_SPREL, K_ADR, K_ADJ, K_STACK, K_MULTI, K_BAD} cism_kind_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cism_mem_type;

  typedef struct packed {
    cism_state_type   st;
    cism_kind_type    kind;
    logic             busy;
    logic             err;
    logic             load;
    logic             pc_ld;
    logic             wb_en;
    logic             wb_sp;
    logic [2:0]       wb_reg;
    logic [1:0]       tail;
    logic [8:0]       mask;
    logic [15:0]      ir;
    logic [31:0]      wb_val;
    logic [31:0]      sp;
    logic [31:0]      lr;
    logic [31:0]      pc;
    logic [3:0]       flags;
    logic [7:0][31:0] r;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    cism_mem_type     mem;
  } cism_regs_type;
endpackage

/* File: logic/cism_exec.sv */
// Executer for stack-relative, address, stack adjust, push/pop and multiple transfer formats
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Stack-relative format stores (bit 0) or loads (bit 1) Rd at SP plus offset.
// - Stack-relative 8-bit word offset is shifted left two into a byte offset.
// - Address format adds offset to PC (bit 0) or SP (bit 1) into Rd.
// - Address format offset is the 8-bit word field shifted left by two.
// - PC operand is instruction address plus four with bit 1 cleared.
// - Address generation leaves the status flags unchanged.
// - Stack adjust adds or subtracts seven-bit magnitude times four, by sign bit.
// - Stack adjust never changes the status flags.
// - Push stores listed low registers, optionally link register, below SP, updates SP.
// - Pop loads listed low registers, optionally PC, from the stack, updates SP.
// - Push is decrement-before store, pop increment-after load: full descending stack.
// - Multiple store writes listed registers upward from base, writes back the base.
// - Multiple load reads listed registers upward from base, writes back final address unless the base is listed.
// - Each instruction takes the cycles of its full-width equivalent.
module cism_exec
  import cism_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core data bus
  output cism_mem_type     mem_req,
  input  wire logic        mem_ready,
  input  wire logic [31:0] mem_rdata
);

  cism_regs_type q;
  cism_regs_type d;

  function automatic logic [3:0] lowest(input logic [8:0] m);
    lowest = 4'h0;
    for (int k = 8; k >= 0; k--) begin
      if (m[k]) lowest = 4'(k);
    end
  endfunction

  function automatic logic [31:0] count4(input logic [8:0] m);
    count4 = 32'h0;
    for (int k = 0; k < 9; k++) begin
      count4 = count4 + {29'h0, m[k], 2'b00};
    end
  endfunction

  function automatic logic [31:0] src(input cism_regs_type s, input logic [3:0] i);
    src = (i == 4'h8) ? s.lr : s.r[i[2:0]];
  endfunction

  function automatic cism_kind_type decode(input logic [15:0] w);
    decode = K_BAD;
    if (w[15:12] == OP_SPREL) decode = K_SPREL;
    else if (w[15:12] == OP_ADR) decode = K_ADR;
    else if (w[15:8] == OP_ADJ) decode = K_ADJ;
    else if (w[15:12] == OP_STACK && w[10:9] == STACK_SUB) decode = K_STACK;
    else if (w[15:12] == OP_MULTI) decode = K_MULTI;
  endfunction

  always_comb begin
    logic        wr;
    logic        do_wb;
    logic        do_fin;
    logic [2:0]  rsel;
    logic [3:0]  idx;
    logic [8:0]  rest;
    logic [31:0] scaled_word_offset;
    logic [31:0] step;
    wr     = 1'b0;
    do_wb  = 1'b0;
    do_fin = 1'b0;
    rsel   = q.ir[10:8];
    idx    = 4'h0;
    rest   = 9'h0;
    scaled_word_offset = {22'h0, q.ir[7:0], 2'b00};
    step   = {23'h0, q.ir[6:0], 2'b00};
    d      = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    // Answer one cycle after setup, so pready and prdata come from flops
    if (psel && !penable && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = 32'h0;
      case (paddr)
        ADDR_INSTR:  d.prdata = {16'h0, q.ir};
        ADDR_STATUS: d.prdata = {30'h0, q.err, q.busy};
        ADDR_PC:     d.prdata = q.pc;
        ADDR_SP:     d.prdata = q.sp;
        ADDR_LR:     d.prdata = q.lr;
        ADDR_FLAGS:  d.prdata = {28'h0, q.flags};
        default: begin
          if (paddr[7:5] == ADDR_GPR[7:5] && paddr[1:0] == 2'b00) d.prdata = q.r[paddr[4:2]];
          else d.pslverr = 1'b1;
        end
      endcase
    end
    // Writes while busy are dropped so software cannot race the sequencer
    wr = psel && penable && q.pready && pwrite && !q.pslverr && !q.busy;
    if (wr) begin
      case (paddr)
        ADDR_INSTR: begin
          d.ir   = pwdata[15:0];
          d.kind = decode(pwdata[15:0]);
          d.err  = (d.kind == K_BAD);
          d.busy = !d.err;
          d.st   = d.err ? S_IDLE : S_EXEC;
        end
        // Status is read-only, so its write is dropped here rather than landing in a register
        ADDR_STATUS: begin
        end
        ADDR_PC:    d.pc = pwdata;
        ADDR_SP:    d.sp = pwdata;
        ADDR_LR:    d.lr = pwdata;
        ADDR_FLAGS: d.flags = pwdata[3:0];
        default:    d.r[paddr[4:2]] = pwdata;
      endcase
    end
    unique case (q.st)
      S_IDLE: begin
      end
      S_EXEC: begin
        d.pc_ld = 1'b0;
        d.wb_en = 1'b0;
        d.mask  = 9'h0;
        d.load  = q.ir[11];
        if (q.kind == K_ADR) begin
          d.r[rsel] = (q.ir[11] ? q.sp : ((q.pc + PC_AHEAD) & ~PC_BIT1)) + scaled_word_offset;
          do_fin = 1'b1;
        end else if (q.kind == K_ADJ) begin
          d.sp   = q.ir[7] ? q.sp - step : q.sp + step;
          do_fin = 1'b1;
        end else begin
          if (q.kind == K_SPREL) begin
            d.mask     = 9'h001 << rsel;
            d.mem.addr = q.sp + scaled_word_offset;
          end else if (q.kind == K_STACK) begin
            d.mask     = {q.ir[8], q.ir[7:0]};
            d.wb_en    = 1'b1;
            d.wb_sp    = 1'b1;
            d.mem.addr = q.ir[11] ? q.sp : q.sp - count4(d.mask);
            d.wb_val   = q.ir[11] ? q.sp + count4(d.mask) : q.sp - count4(d.mask);
            d.pc_ld    = q.ir[11] && q.ir[8];
          end else begin
            d.mask     = {1'b0, q.ir[7:0]};
            d.wb_en    = 1'b1;
            d.wb_sp    = 1'b0;
            d.wb_reg   = rsel;
            d.mem.addr = q.r[rsel];
            d.wb_val   = q.r[rsel] + count4(d.mask);
          end
          if (d.mask == 9'h0) begin
            do_wb  = 1'b1;
            do_fin = 1'b1;
          end else begin
            d.st        = S_MEM;
            d.mem.valid = 1'b1;
            d.mem.write = !q.ir[11];
            d.mem.wdata = src(q, lowest(d.mask));
          end
        end
      end
      S_MEM: begin
        if (mem_ready) begin
          idx    = lowest(q.mask);
          rest   = q.mask & ~(9'h001 << idx);
          d.mask = rest;
          if (q.load) begin
            if (idx == 4'h8) d.pc = mem_rdata & ~PC_BIT0;
            else d.r[idx[2:0]] = mem_rdata;
          end
          if (rest != 9'h0) begin
            d.mem.addr  = q.mem.addr + WORD_STEP;
            d.mem.wdata = src(q, lowest(rest));
          end else begin
            d.mem.valid = 1'b0;
            do_wb       = 1'b1;
            if (q.load) begin
              d.tail = q.pc_ld ? PCLOAD_TAIL : LOAD_TAIL;
              d.st   = S_TAIL;
            end else begin
              do_fin = 1'b1;
            end
          end
        end
      end
      S_TAIL: begin
        d.tail = q.tail - 2'h1;
        if (q.tail == 2'h1) do_fin = 1'b1;
      end
    endcase
    // A base that was itself loaded keeps the loaded word
    if (do_wb && d.wb_en) begin
      if (d.wb_sp) d.sp = d.wb_val;
      else if (!(d.load && d.ir[d.wb_reg])) d.r[d.wb_reg] = d.wb_val;
    end
    if (do_fin) begin
      d.st   = S_IDLE;
      d.busy = 1'b0;
      if (!d.pc_ld) d.pc = q.pc + INSN_STEP;
    end
    // Flags are only ever written from the bus, never by execution
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign mem_req = q.mem;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_sprel;
    q.st == S_EXEC && q.kind == K_SPREL |=> mem_req.valid && mem_req.write == !$past(q.ir[11])
      && mem_req.addr == $past(q.sp) + {22'h0, $past(q.ir[7:0]), 2'b00};
  endproperty
  a_sprel: assert property (p_sprel) else $error("stack-relative address wrong");

  property p_adr;
    q.st == S_EXEC && q.kind == K_ADR |=> q.r[$past(q.ir[10:8])] == ($past(q.ir[11]) ? $past(q.sp)
      : (($past(q.pc) + 32'h4) & ~32'h2)) + {22'h0, $past(q.ir[7:0]), 2'b00};
  endproperty
  a_adr: assert property (p_adr) else $error("address generation result wrong");

  property p_flags;
    q.busy |=> $stable(q.flags);
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed during execution");

  property p_adj;
    q.st == S_EXEC && q.kind == K_ADJ |=> q.sp == ($past(q.ir[7])
      ? $past(q.sp) - {23'h0, $past(q.ir[6:0]), 2'b00} : $past(q.sp) + {23'h0, $past(q.ir[6:0]), 2'b00});
  endproperty
  a_adj: assert property (p_adj) else $error("stack adjust wrong");

  property p_push;
    q.st == S_EXEC && q.kind == K_STACK && !q.ir[11] && q.ir[8:0] != 9'h0
      |=> mem_req.write && mem_req.addr == $past(q.sp) - count4($past(q.ir[8:0]));
  endproperty
  a_push: assert property (p_push) else $error("push start address wrong");

  property p_pop;
    q.st == S_EXEC && q.kind == K_STACK && q.ir[11] && q.ir[8:0] != 9'h0
      |=> !mem_req.write && mem_req.addr == $past(q.sp);
  endproperty
  a_pop: assert property (p_pop) else $error("pop start address wrong");

  property p_step;
    mem_req.valid && mem_ready && (q.mask & (q.mask - 9'h1)) != 9'h0
      |=> mem_req.valid && mem_req.addr == $past(mem_req.addr) + 32'h4;
  endproperty
  a_step: assert property (p_step) else $error("transfer address not ascending");

  property p_hold;
    mem_req.valid && !mem_ready |=> $stable(mem_req);
  endproperty
  a_hold: assert property (p_hold) else $error("bus request changed while waiting");

  property p_wb;
    q.st == S_MEM && mem_ready && q.kind == K_MULTI && (q.mask & (q.mask - 9'h1)) == 9'h0
      && !(q.load && q.ir[q.wb_reg]) |=> q.r[$past(q.wb_reg)] == $past(q.wb_val);
  endproperty
  a_wb: assert property (p_wb) else $error("base writeback wrong");

  property p_tail;
    q.st == S_MEM && mem_ready && q.load && !q.pc_ld && (q.mask & (q.mask - 9'h1)) == 9'h0
      |=> q.st == S_TAIL ##1 !q.busy;
  endproperty
  a_tail: assert property (p_tail) else $error("load tail length wrong");

  property p_pctail;
    q.st == S_MEM && mem_ready && q.load && q.pc_ld && (q.mask & (q.mask - 9'h1)) == 9'h0
      |=> q.st == S_TAIL ##2 q.busy ##1 !q.busy;
  endproperty
  a_pctail: assert property (p_pctail) else $error("program counter load tail length wrong");

  property p_store;
    q.st == S_MEM && mem_ready && !q.load && (q.mask & (q.mask - 9'h1)) == 9'h0 |=> !q.busy;
  endproperty
  a_store: assert property (p_store) else $error("store did not end after last word");

  property p_load;
    q.st == S_MEM && mem_ready && q.load && lowest(q.mask) != 4'h8
      |=> q.r[3'($past(lowest(q.mask)))] == $past(mem_rdata);
  endproperty
  a_load: assert property (p_load) else $error("loaded word not in listed register");

endmodule
`default_nettype wire

/* File: dv/cism_mem_model.sv */
// Memory system model on the far side of the core data bus
`timescale 1ns/1ps
`default_nettype none
module cism_mem_model
  import cism_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Core data bus
  input  wire cism_mem_type mem_req,
  output logic              mem_ready,
  output logic       [31:0] mem_rdata,
  // Wait states per access
  input  wire logic  [1:0]  waits
);
  logic [31:0] mem [0:255];
  logic [31:0] log_q [$];
  logic [1:0]  wcnt;
  logic        flip;
  initial for (int i = 0; i < 256; i++) mem[i] = ~(i * 32'h0101_0101);
  assign mem_ready = mem_req.valid && (wcnt == waits);
  // Data toggle outside an accepted cycle, so a stale word never reads as good
  assign mem_rdata = mem_ready ? mem[mem_req.addr[9:2]] : {32{flip}};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt <= 2'h0;
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
      wcnt <= (mem_ready || !mem_req.valid) ? 2'h0 : wcnt + 2'h1;
      if (mem_ready) begin
        log_q.push_back(mem_req.addr);
        if (mem_req.write) mem[mem_req.addr[9:2]] <= mem_req.wdata;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Testbench for the compact stack and memory executer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cism_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ready, err_seen;
  logic  [7:0]  paddr;
  logic  [31:0] pwdata, prdata, mem_rdata, q;
  logic  [1:0]  waits;
  cism_mem_type mem_req;
  int           n_errors, n_compared;

  cism_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  cism_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .waits(waits));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the edge that samples pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never drives psel twice in one step
    @(posedge pclk);
  endtask

  function automatic logic [7:0] gpr(input int i);
    return ADDR_GPR + 8'(4 * i);
  endfunction

  function automatic logic [31:0] word(input logic [31:0] a);
    return mem_u.mem[a[9:2]];
  endfunction

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic run(input logic [15:0] instr);
    int i;
    xfer(1'b1, ADDR_INSTR, {16'h0, instr});
    for (i = 0; i < 40; i++) begin
      xfer(1'b0, ADDR_STATUS, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (i == 40) chk(q, 32'h0);
  endtask

  task automatic t_sprel();
    xfer(1'b1, ADDR_SP, 32'h100);
    xfer(1'b1, gpr(3), 32'h1234_5678);
    run({OP_SPREL, 1'b0, 3'd3, 8'hff});
    chk(word(32'h100 + 32'd1020), 32'h1234_5678);
    mem_u.mem[8'((32'h100 + 32'd492) >> 2)] = 32'hcafe_0001;
    run({OP_SPREL, 1'b1, 3'd5, 8'd123});
    rdchk(gpr(5), 32'hcafe_0001);
  endtask

  task automatic t_adr();
    xfer(1'b1, ADDR_PC, 32'h1006);
    xfer(1'b1, ADDR_FLAGS, 32'ha);
    run({OP_ADR, 1'b0, 3'd2, 8'd143});
    rdchk(gpr(2), ((32'h1006 + 32'h4) & ~32'h2) + 32'd572);
    run({OP_ADR, 1'b1, 3'd6, 8'd53});
    rdchk(gpr(6), 32'h100 + 32'd212);
    rdchk(ADDR_FLAGS, 32'ha);
  endtask

  task automatic t_adj();
    run({OP_ADJ, 1'b0, 7'd67});
    rdchk(ADDR_SP, 32'h100 + 32'd268);
    run({OP_ADJ, 1'b1, 7'd26});
    rdchk(ADDR_SP, 32'h100 + 32'd268 - 32'd104);
    run({OP_ADJ, 1'b0, 7'h7f});
    rdchk(ADDR_SP, 32'h100 + 32'd164 + 32'd508);
    rdchk(ADDR_FLAGS, 32'ha);
  endtask

  // Slow memory: every word waits three cycles
  task automatic t_stack();
    waits <= 2'h3;
    xfer(1'b1, ADDR_SP, 32'h200);
    xfer(1'b1, gpr(0), 32'haaaa_0000);
    xfer(1'b1, gpr(2), 32'hbbbb_0002);
    xfer(1'b1, ADDR_LR, 32'h0000_4001);
    mem_u.log_q.delete();
    run({OP_STACK, 1'b0, STACK_SUB, 1'b1, 8'h05});
    rdchk(ADDR_SP, 32'h1f4);
    chk(word(32'h1f4), 32'haaaa_0000);
    chk(word(32'h1f8), 32'hbbbb_0002);
    chk(word(32'h1fc), 32'h0000_4001);
    chk(32'(mem_u.log_q.size()), 32'h3);
    chk(mem_u.log_q[0], 32'h1f4);
    run({OP_STACK, 1'b1, STACK_SUB, 1'b1, 8'h0a});
    rdchk(gpr(1), 32'haaaa_0000);
    rdchk(gpr(3), 32'hbbbb_0002);
    rdchk(ADDR_PC, 32'h0000_4000);
    rdchk(ADDR_SP, 32'h200);
    waits <= 2'h0;
  endtask

  task automatic t_multi();
    xfer(1'b1, gpr(0), 32'h300);
    for (int i = 3; i < 8; i++) xfer(1'b1, gpr(i), 32'h3300 + i);
    run({OP_MULTI, 1'b0, 3'd0, 8'hf8});
    for (int i = 3; i < 8; i++) chk(word(32'h300 + 4 * (i - 3)), 32'h3300 + i);
    rdchk(gpr(0), 32'h314);
    xfer(1'b1, gpr(1), 32'h304);
    run({OP_MULTI, 1'b1, 3'd1, 8'h14});
    rdchk(gpr(2), 32'h3304);
    rdchk(gpr(4), 32'h3305);
    rdchk(gpr(1), 32'h30c);
  endtask

  // Status is read-only; an unknown opcode only raises the error bit
  task automatic t_status();
    xfer(1'b1, ADDR_STATUS, 32'hffff_ffff);
    rdchk(gpr(1), 32'h30c);
    rdchk(ADDR_PC, 32'h4004);
    run(16'h0000);
    rdchk(ADDR_STATUS, 32'h2);
    rdchk(ADDR_PC, 32'h4004);
    run({OP_ADJ, 1'b0, 7'd0});
    rdchk(ADDR_STATUS, 32'h0);
    rdchk(ADDR_PC, 32'h4006);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, waits} = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(8'h18, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    t_sprel();
    t_adr();
    t_adj();
    t_stack();
    t_multi();
    t_status();
    conclude();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200_000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
